/* File: logic/lve_defs.svh */
// Purpose: Offsets, field positions, vectors and reset values.
// Assumes: Included by bare name from the exception detect files.
// Notes: Definitions only.
`ifndef LVE_DEFS_SVH
`define LVE_DEFS_SVH
`define LVE_OFF_DBG_CTRL 12'h000
`define LVE_OFF_DBG_STAT 12'h004
`define LVE_OFF_CFG 12'h008
`define LVE_OFF_EXC_INFO 12'h00c
`define LVE_OFF_EXC_IP 12'h010
`define LVE_VEC_DE 8'h00
`define LVE_VEC_DB 8'h01
`define LVE_VEC_NMI 8'h02
`define LVE_VEC_BP 8'h03
`define LVE_VEC_OF 8'h04
`define LVE_VEC_BR 8'h05
`define LVE_VEC_UD 8'h06
`define LVE_VEC_NM 8'h07
`define LVE_VEC_RSVD 8'h20
`define LVE_CTL_W 5
`define LVE_CTL_RST 5'h00
`define LVE_CTL_IBP 0
`define LVE_CTL_DBP 1
`define LVE_CTL_IOBP 2
`define LVE_CTL_TSW 3
`define LVE_CTL_GD 4
`define LVE_STAT_W 7
`define LVE_ST_IBP 0
`define LVE_ST_DBP 1
`define LVE_ST_IOBP 2
`define LVE_ST_STEP 3
`define LVE_ST_TSW 4
`define LVE_ST_GD 5
`define LVE_ST_DEBUG_TRAP_OPCODE 6
`define LVE_CFG_W 6
`define LVE_CFG_RST 6'h00
`define LVE_CFG_MP 0
`define LVE_CFG_EM 1
`define LVE_CFG_TS 2
`define LVE_CFG_FXSR 3
`define LVE_CFG_XMMEX 4
`define LVE_CFG_DE 5
`endif

/* File: logic/lve_pkg.sv */
// Purpose: Types shared by the exception detect block.
// Assumes: Nothing beyond the constants header.
// Notes: State of the report handshake.
package lve_pkg;
  typedef enum logic {
    LVE_IDLE,
    LVE_HOLD
  } lve_state_e;
endpackage

/* File: logic/lve_sync2.sv */
// Purpose: Two flip-flop synchroniser for an asynchronous level.
// Assumes: Input from outside the clk_sys domain.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module lve_sync2 (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic d_async,
  output logic q_sync
);
  logic meta_reg;
  ////////////////////////////////////////////////////////////////////
  // Both stages clear under reset.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_reg <= 1'b0;
      q_sync <= 1'b0;
    end else begin
      meta_reg <= d_async;
      q_sync <= meta_reg;
    end
  end
endmodule // lve_sync2
`default_nettype wire

/* File: logic/lve_sticky.sv */
// Purpose: Vector of sticky flags with set winning over clear.
// Assumes: Set and clear come from the clk_sys domain.
// Notes: Used for debug status and the pending interrupt.
`timescale 1ns/1ps
`default_nettype none
module lve_sticky #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  ////////////////////////////////////////////////////////////////////
  // An event in the clearing cycle is kept.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= set | (q & ~clr);
    end
  end
endmodule // lve_sticky
`default_nettype wire

/* File: logic/lve_detect.sv */
// Purpose: Detects and reports exception vectors 0 to 7.
// Assumes: Pipeline events arrive on clk_sys; nmi_pin is asynchronous.
// Notes: One instruction is judged per ins_valid and ins_ready.
`timescale 1ns/1ps
`default_nettype none
`include "lve_defs.svh"

// Functional notes
// - Zero divisor or quotient overflow raises vector 0.
// - Divide error saves the divide's address.
// - Enabled debug causes and opcode raise vector 1.
// - Debug cause goes to status, no code.
// - Instruction and detect faults; other debug causes trap.
// - Resume flag clears after each completed instruction but interrupt return and gate transfer.
// - Other exceptions push resume flag as one.
// - Resume flag skips one instruction breakpoint.
// - Debug exception pushes resume flag as zero.
// - Interrupt taken at boundary as vector 2.
// - Interrupt recognition blocked until interrupt return.
// - Breakpoint instruction traps vector 3, next byte.
// - Overflow check with flag set traps 4.
// - Out of bounds index faults vector 5.
// - Undefined opcodes and bad lock raise 6.
// - Mode illegal instructions raise vector 6.
// - Control bit conditions raise vector 6.
// - Invalid opcode is a fault, no code.
// - Coprocessor state conditions raise vector 7.
// - Vector 7 is a fault, no code.
// - Eight bit vector, low ones predefined.
module lve_detect #(
  parameter int IP_W = 32
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ins_valid,
  output logic ins_ready,
  input wire logic [IP_W-1:0] ins_ip,
  input wire logic [IP_W-1:0] ins_next_ip,
  input wire logic ins_div,
  input wire logic div_zero,
  input wire logic div_ovf,
  input wire logic ins_debug_trap_opcode,
  input wire logic ins_breakpoint_instruction,
  input wire logic ins_into,
  input wire logic overflow_flag,
  input wire logic ins_bound,
  input wire logic bound_out,
  input wire logic ins_undef,
  input wire logic ins_ud2,
  input wire logic lock_unlockable,
  input wire logic lock_non_mem,
  input wire logic bad_operand,
  input wire logic ins_fast_sys,
  input wire logic ins_legacy64,
  input wire logic ins_desc_tbl,
  input wire logic ins_vec,
  input wire logic ins_media,
  input wire logic vec_num_exc,
  input wire logic ins_dr_access,
  input wire logic ins_dr_alias,
  input wire logic ins_rsm,
  input wire logic ins_fp,
  input wire logic ins_float_wait_instruction,
  input wire logic ins_interrupt_return,
  input wire logic interrupt_return_rf_pop,
  input wire logic ins_gate_xfer,
  input wire logic string_intr,
  input wire logic ibp_hit,
  input wire logic dbp_hit,
  input wire logic iobp_hit,
  input wire logic task_switch,
  input wire logic single_step_flag,
  input wire logic long_mode,
  input wire logic mode64,
  input wire logic prot_mode,
  input wire logic v86_mode,
  input wire logic system_management_mode,
  input wire logic nmi_pin,
  input wire logic exc_ack,
  output logic exc_valid,
  output logic [7:0] exc_vector,
  output logic exc_err_code,
  output logic [IP_W-1:0] exc_ip,
  output logic exc_is_fault,
  output logic exc_rf_image,
  output logic resume_flag,
  output logic nmi_blocked
);
  ////////////////////////////////////////////////////////////////////
  // Declarations.
  lve_pkg::lve_state_e state_reg, state_next;
  logic [`LVE_CTL_W-1:0] ctl_reg;
  logic [`LVE_CFG_W-1:0] cfg_reg;
  logic [`LVE_STAT_W-1:0] stat_q, stat_set, stat_clr;
  logic nmi_s, nmi_q_reg, nmi_pend, nmi_rise, nmi_clr;
  logic go, take_nmi, complete;
  logic ibp, gd, dbg_fault, ud, nm, de, br, bp, ofl, dbg_trap;
  logic any_fault, any_exc, rf_next;
  logic [7:0] vec_sel;
  logic fault_sel;
  logic wr_go, setup_rd;
  logic sel_ctl, sel_stat, sel_cfg, sel_info, sel_ip, mapped;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////
  // Interrupt pin synchroniser and edge latch.
  lve_sync2 u_nmi_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d_async(nmi_pin),
    .q_sync(nmi_s)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nmi_q_reg <= 1'b0;
    end else begin
      nmi_q_reg <= nmi_s;
    end
  end

  // A new edge latches even while recognition is blocked.
  assign nmi_rise = nmi_s & ~nmi_q_reg;
  assign nmi_clr = take_nmi;

  lve_sticky #(
    .W(1)
  ) u_nmi_pend (
    .clk_sys(clk_sys),
    .srst(srst),
    .set(nmi_rise),
    .clr(nmi_clr),
    .q(nmi_pend)
  );

  ////////////////////////////////////////////////////////////////////
  // Instruction acceptance and boundary decisions.
  assign go = ins_valid & ins_ready;
  assign take_nmi = go & nmi_pend & ~nmi_blocked;

  ////////////////////////////////////////////////////////////////////
  // Cause detection for the offered instruction.
  // Resume flag masks breakpoint.
  assign ibp = ctl_reg[`LVE_CTL_IBP] & ibp_hit & ~resume_flag;
  assign gd = ctl_reg[`LVE_CTL_GD] & ins_dr_access;
  assign dbg_fault = ibp | gd;
  assign ud = ins_undef | ins_ud2 | lock_unlockable | lock_non_mem
    | bad_operand | (ins_fast_sys & long_mode)
    | (ins_legacy64 & mode64)
    | (ins_desc_tbl & (~prot_mode | v86_mode))
    | (ins_vec & ~cfg_reg[`LVE_CFG_FXSR])
    | ((ins_vec | ins_media) & cfg_reg[`LVE_CFG_EM])
    | (vec_num_exc & ~cfg_reg[`LVE_CFG_XMMEX])
    | (ins_dr_alias & cfg_reg[`LVE_CFG_DE])
    | (ins_rsm & ~system_management_mode);
  assign nm = (ins_float_wait_instruction & cfg_reg[`LVE_CFG_MP] & cfg_reg[`LVE_CFG_TS])
    | (ins_fp & ~ins_float_wait_instruction & cfg_reg[`LVE_CFG_EM])
    | ((ins_fp & ~ins_float_wait_instruction | ins_vec | ins_media) & cfg_reg[`LVE_CFG_TS]);
  assign de = ins_div & (div_zero | div_ovf);
  assign br = ins_bound & bound_out;
  assign bp = ins_breakpoint_instruction;
  assign ofl = ins_into & overflow_flag;
  assign dbg_trap = ins_debug_trap_opcode | single_step_flag
    | (ctl_reg[`LVE_CTL_DBP] & dbp_hit)
    | (ctl_reg[`LVE_CTL_IOBP] & iobp_hit)
    | (ctl_reg[`LVE_CTL_TSW] & task_switch);
  assign any_fault = dbg_fault | ud | nm | de | br;
  assign any_exc = any_fault | bp | ofl | dbg_trap;
  assign complete = go & ~take_nmi & ~any_fault;

  ////////////////////////////////////////////////////////////////////
  // One vector per instruction: faults first, then traps.
  always_comb begin
    vec_sel = `LVE_VEC_RSVD;
    fault_sel = 1'b0;
    if (dbg_fault) begin
      vec_sel = `LVE_VEC_DB;
      fault_sel = 1'b1;
    end else if (ud) begin
      vec_sel = `LVE_VEC_UD;
      fault_sel = 1'b1;
    end else if (nm) begin
      vec_sel = `LVE_VEC_NM;
      fault_sel = 1'b1;
    end else if (de) begin
      vec_sel = `LVE_VEC_DE;
      fault_sel = 1'b1;
    end else if (br) begin
      vec_sel = `LVE_VEC_BR;
      fault_sel = 1'b1;
    end else if (bp) begin
      vec_sel = `LVE_VEC_BP;
    end else if (ofl) begin
      vec_sel = `LVE_VEC_OF;
    end else if (dbg_trap) begin
      vec_sel = `LVE_VEC_DB;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Debug status: fault causes always, trap causes only without a fault, none when the interrupt is taken; vectored once.
  // Status recording.
  always_comb begin
    stat_set = '0;
    if (go & ~take_nmi) begin
      stat_set[`LVE_ST_IBP] = ibp;
      stat_set[`LVE_ST_GD] = gd;
      if (~any_fault) begin
        stat_set[`LVE_ST_DEBUG_TRAP_OPCODE] = ins_debug_trap_opcode;
        stat_set[`LVE_ST_STEP] = single_step_flag;
        stat_set[`LVE_ST_DBP] = ctl_reg[`LVE_CTL_DBP] & dbp_hit;
        stat_set[`LVE_ST_IOBP] = ctl_reg[`LVE_CTL_IOBP] & iobp_hit;
        stat_set[`LVE_ST_TSW] = ctl_reg[`LVE_CTL_TSW] & task_switch;
      end
    end
  end

  lve_sticky #(
    .W(`LVE_STAT_W)
  ) u_dbg_stat (
    .clk_sys(clk_sys),
    .srst(srst),
    .set(stat_set),
    .clr(stat_clr),
    .q(stat_q)
  );

  ////////////////////////////////////////////////////////////////////
  // Resume flag after a completed instruction.
  // Clear unless return or gate transfer.
  assign rf_next = ins_interrupt_return ? interrupt_return_rf_pop :
    (ins_gate_xfer ? resume_flag : 1'b0);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      resume_flag <= 1'b0;
    end else if (complete) begin
      resume_flag <= rf_next;
    end
  end

  // Recognition block, released by a completed interrupt return.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nmi_blocked <= 1'b0;
    end else if (take_nmi) begin
      nmi_blocked <= 1'b1;
    end else if (complete & ins_interrupt_return) begin
      nmi_blocked <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Report handshake: held until the dispatcher acknowledges.
  // One report at a time.
  always_comb begin
    case (state_reg)
      lve_pkg::LVE_IDLE: begin
        state_next = (take_nmi | (go & any_exc)) ?
          lve_pkg::LVE_HOLD : lve_pkg::LVE_IDLE;
      end
      lve_pkg::LVE_HOLD: begin
        state_next = exc_ack ? lve_pkg::LVE_IDLE : lve_pkg::LVE_HOLD;
      end
      default: begin
        state_next = lve_pkg::LVE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= lve_pkg::LVE_IDLE;
      ins_ready <= 1'b0;
      exc_valid <= 1'b0;
    end else begin
      state_reg <= state_next;
      ins_ready <= (state_next == lve_pkg::LVE_IDLE);
      exc_valid <= (state_next == lve_pkg::LVE_HOLD);
    end
  end

  // Captured report fields; no vector here pushes an error code.
  // Eight bit vector field.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      exc_vector <= 8'h00;
      exc_err_code <= 1'b0;
      exc_ip <= '0;
      exc_is_fault <= 1'b0;
      exc_rf_image <= 1'b0;
    end else if (take_nmi) begin
      exc_vector <= `LVE_VEC_NMI;
      exc_ip <= ins_ip;
      exc_is_fault <= 1'b0;
      exc_rf_image <= string_intr | resume_flag;
    end else if (state_reg == lve_pkg::LVE_IDLE && go && any_exc) begin
      exc_vector <= vec_sel;
      exc_ip <= fault_sel ? ins_ip : ins_next_ip;
      exc_is_fault <= fault_sel;
      exc_rf_image <= (vec_sel != `LVE_VEC_DB);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB slave: zero wait, error on unmapped word.
  assign sel_ctl = (paddr == `LVE_OFF_DBG_CTRL);
  assign sel_stat = (paddr == `LVE_OFF_DBG_STAT);
  assign sel_cfg = (paddr == `LVE_OFF_CFG);
  assign sel_info = (paddr == `LVE_OFF_EXC_INFO);
  assign sel_ip = (paddr == `LVE_OFF_EXC_IP);
  assign mapped = sel_ctl | sel_stat | sel_cfg | sel_info | sel_ip;
  assign setup_rd = psel & ~penable;
  assign wr_go = psel & penable & pready & pwrite & mapped;
  assign stat_clr = (wr_go & sel_stat) ? pwdata[`LVE_STAT_W-1:0] : '0;

  // Read data selection.
  assign rd_mux = sel_ctl ? {{(32-`LVE_CTL_W){1'b0}}, ctl_reg} :
    sel_stat ? {{(32-`LVE_STAT_W){1'b0}}, stat_q} :
    sel_cfg ? {{(32-`LVE_CFG_W){1'b0}}, cfg_reg} :
    sel_info ? {19'h00000, nmi_blocked, resume_flag, exc_rf_image,
      exc_is_fault, exc_err_code, exc_vector} :
    sel_ip ? 32'(exc_ip) : 32'h00000000;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_rd;
      pslverr <= setup_rd & ~mapped;
      prdata <= (setup_rd & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Writable control registers.
  // Software enables.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctl_reg <= `LVE_CTL_RST;
      cfg_reg <= `LVE_CFG_RST;
    end else if (wr_go) begin
      if (sel_ctl) begin
        ctl_reg <= pwdata[`LVE_CTL_W-1:0];
      end
      if (sel_cfg) begin
        cfg_reg <= pwdata[`LVE_CFG_W-1:0];
      end
    end
  end
endmodule // lve_detect
`default_nettype wire

/* File: sim/lve_detect_assertions.sv */
// Purpose: Concurrent checks on the exception reports of the detect block.
// Assumes: Attached by bind to every lve_detect.
// Notes: Watches block ports only.
`timescale 1ns/1ps
`default_nettype none
module lve_detect_assertions #(
  parameter int IP_W = 32
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ins_ready,
  input wire logic [IP_W-1:0] ins_ip,
  input wire logic [IP_W-1:0] ins_next_ip,
  input wire logic exc_ack,
  input wire logic exc_valid,
  input wire logic [7:0] exc_vector,
  input wire logic exc_err_code,
  input wire logic [IP_W-1:0] exc_ip,
  input wire logic exc_is_fault,
  input wire logic exc_rf_image,
  input wire logic nmi_blocked
);
  // All checks use the core clock and pause during reset.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // A new report points at the cause or at the next instruction.
  fault_ip_a: assert property (
    $rose(exc_valid) && exc_is_fault |-> exc_ip == $past(ins_ip))
    else $error("Fault report pointer is wrong.");
  trap_ip_a: assert property (
    $rose(exc_valid) && !exc_is_fault && exc_vector != 8'h02 |-> exc_ip == $past(ins_next_ip))
    else $error("Trap report pointer is wrong.");
  // Kind, error code and resume image follow the vector.
  fault_kind_a: assert property (
    $rose(exc_valid) && exc_vector != 8'h01 && exc_vector != 8'h02
      |-> exc_is_fault == !(exc_vector inside {8'h03, 8'h04}))
    else $error("Fault or trap kind is wrong.");
  no_code_a: assert property (
    exc_valid |-> !exc_err_code)
    else $error("Error code flag set.");
  debug_rf_a: assert property (
    exc_valid && exc_vector == 8'h01 |-> !exc_rf_image)
    else $error("Debug report pushes resume flag set.");
  other_rf_a: assert property (
    exc_valid && exc_vector != 8'h01 && exc_vector != 8'h02 |-> exc_rf_image)
    else $error("Exception report pushes resume flag clear.");
  // The report holds until taken and then makes way.
  report_hold_a: assert property (
    exc_valid && !exc_ack |=> exc_valid && $stable(exc_vector) && $stable(exc_ip))
    else $error("Report changed before it was taken.");
  ack_release_a: assert property (
    exc_valid && exc_ack |=> !exc_valid && ins_ready)
    else $error("Report not released after acknowledge.");
  one_report_a: assert property (
    exc_valid |-> !ins_ready)
    else $error("Instruction accepted while a report is held.");
  nmi_block_a: assert property (
    $rose(exc_valid) && exc_vector == 8'h02 |-> !$past(nmi_blocked))
    else $error("Interrupt taken while blocked.");
endmodule // lve_detect_assertions
bind lve_detect lve_detect_assertions #(.IP_W(IP_W)) u_lve_detect_assertions (
  .clk_sys, .srst, .ins_ready, .ins_ip, .ins_next_ip, .exc_ack, .exc_valid, .exc_vector,
  .exc_err_code, .exc_ip, .exc_is_fault, .exc_rf_image, .nmi_blocked);
`default_nettype wire

/* File: sim/lve_pipe_model.sv */
// Purpose: Dispatcher and interrupt source beside the detect block.
// Assumes: Requests come from the bench on clk_sys.
// Notes: ack_dly sets how slowly reports are taken.
`timescale 1ns/1ps
`default_nettype none
module lve_pipe_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [1:0] ack_dly,
  input wire logic nmi_req,
  input wire logic exc_valid,
  output logic exc_ack,
  output logic nmi_pin
);
  logic [1:0] wait_reg;
  logic [2:0] nmi_reg;
  // Take a held report after ack_dly cycles, one pulse per report.
  always_ff @(posedge clk_sys) begin
    if (srst || !exc_valid || exc_ack) begin
      wait_reg <= 2'h0;
    end else if (wait_reg != 2'h3) begin
      wait_reg <= wait_reg + 2'h1;
    end
    exc_ack <= !srst && exc_valid && !exc_ack && wait_reg >= ack_dly;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nmi_reg <= 3'h0;
    end else if (nmi_req) begin
      nmi_reg <= 3'h4;
    end else if (nmi_reg != 3'h0) begin
      nmi_reg <= nmi_reg - 3'h1;
    end
    nmi_pin <= nmi_reg != 3'h0;
  end
endmodule // lve_pipe_model
`default_nettype wire

/* File: sim/low_vector_exception_detect_bench.sv */
// Purpose: Self-checking bench for the exception detect block.
// Assumes: Qualifier bits of q follow the instance connections.
// Notes: k[1] is fault, k[0] the pushed resume image.
`timescale 1ns/1ps
`default_nettype none
`include "lve_defs.svh"
module low_vector_exception_detect_bench;
  logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, err;
  logic ins_valid, ins_ready, nmi_req, nmi_pin, exc_ack, exc_valid;
  logic exc_err_code, exc_is_fault, exc_rf_image, resume_flag, nmi_blocked;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ins_ip, ins_next_ip, exc_ip, ip_cur;
  logic [7:0] exc_vector;
  logic [38:0] q;
  logic [1:0] ack_dly;
  int n_mismatch, cmp_count, cyc;
  lve_detect u_lve_detect (
    .clk_sys, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .ins_valid, .ins_ready, .ins_ip, .ins_next_ip, .ins_div(q[0]), .div_zero(q[1]),
    .div_ovf(q[2]), .ins_debug_trap_opcode(q[3]), .ins_breakpoint_instruction(q[4]), .ins_into(q[5]), .overflow_flag(q[6]),
    .ins_bound(q[7]), .bound_out(q[8]), .ins_undef(q[9]), .ins_ud2(q[10]),
    .lock_unlockable(q[11]), .lock_non_mem(q[12]), .bad_operand(q[13]),
    .ins_fast_sys(q[14]), .ins_legacy64(q[15]), .ins_desc_tbl(q[16]), .ins_vec(q[17]),
    .ins_media(q[18]), .vec_num_exc(q[19]), .ins_dr_access(q[20]), .ins_dr_alias(q[21]),
    .ins_rsm(q[22]), .ins_fp(q[23]), .ins_float_wait_instruction(q[24]), .ins_interrupt_return(q[25]),
    .interrupt_return_rf_pop(q[26]), .ins_gate_xfer(q[27]), .string_intr(q[28]), .ibp_hit(q[29]),
    .dbp_hit(q[30]), .iobp_hit(q[31]), .task_switch(q[32]), .single_step_flag(q[33]),
    .long_mode(q[34]), .mode64(q[35]), .prot_mode(q[36]), .v86_mode(q[37]),
    .system_management_mode(q[38]), .nmi_pin, .exc_ack, .exc_valid, .exc_vector,
    .exc_err_code, .exc_ip, .exc_is_fault, .exc_rf_image, .resume_flag, .nmi_blocked);
  lve_pipe_model u_lve_pipe_model (
    .clk_sys, .srst, .ack_dly, .nmi_req, .exc_valid, .exc_ack, .nmi_pin);
  ////////////////////////////////////////
  // Verdict, counts and comparisons.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // One register bus transfer; read data and refusal land in rd and err.
  // Waits for pready with no limit of its own; the cycle guard ends a hang.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Offer one instruction with qualifiers m; v of ff means no report.
  task automatic xi(input logic [38:0] m, input logic [7:0] v, input logic [1:0] k);
    ip_cur = ip_cur + 32'h10;
    q <= m;
    ins_ip <= ip_cur;
    ins_next_ip <= ip_cur + 32'h3;
    ins_valid <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (ins_ready !== 1'b1);
    q <= '0;
    ins_valid <= 1'b0;
    @(posedge clk_sys);
    if (v == 8'hff) begin
      chk1(exc_valid, 1'b0);
    end else begin
      chk1(exc_valid, 1'b1);
      chk({24'h0, exc_vector}, {24'h0, v});
      chk(exc_ip, k[1] ? ip_cur : ip_cur + 32'h3);
      if (v != 8'h02) begin
        chk1(exc_is_fault, k[1]);
      end
      chk1(exc_rf_image, k[0]);
      chk1(exc_err_code, 1'b0);
      while (exc_valid === 1'b1) begin
        @(posedge clk_sys);
      end
    end
  endtask
  task automatic nmi_pulse();
    nmi_req <= 1'b1;
    @(posedge clk_sys);
    nmi_req <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////
  // Clock and hang guard.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // Main sequence.
  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, ins_valid, nmi_req, paddr, pwdata, q, ack_dly} = '0;
    {ins_ip, ins_next_ip} = '0;
    ip_cur = 32'h1000;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    apb(1'b1, `LVE_OFF_DBG_CTRL, 32'hffffffff);
    apb(1'b0, `LVE_OFF_DBG_CTRL, 32'h0);
    chk(rd, 32'h1f);
    apb(1'b0, 12'h100, 32'h0);
    chk1(err, 1'b1);
    apb(1'b1, `LVE_OFF_DBG_CTRL, 32'h0);
    ack_dly <= 2'h3;
    xi(39'h3, 8'h00, 2'b11);
    xi(39'h5, 8'h00, 2'b11);
    xi(39'h1, 8'hff, 2'b00);
    xi(39'h10, 8'h03, 2'b01);
    xi(39'h60, 8'h04, 2'b01);
    xi(39'h20, 8'hff, 2'b00);
    xi(39'h180, 8'h05, 2'b11);
    xi(39'h80, 8'hff, 2'b00);
    ack_dly <= 2'h0;
    xi(39'h200, 8'h06, 2'b11);
    xi(39'h400, 8'h06, 2'b11);
    xi(39'h800, 8'h06, 2'b11);
    xi(39'h1000, 8'h06, 2'b11);
    xi(39'h2000, 8'h06, 2'b11);
    xi(39'h400004000, 8'h06, 2'b11);
    xi(39'h800008000, 8'h06, 2'b11);
    xi(39'h10000, 8'h06, 2'b11);
    xi(39'h3000010000, 8'h06, 2'b11);
    xi(39'h1000010000, 8'hff, 2'b00);
    xi(39'h400000, 8'h06, 2'b11);
    xi(39'h4000400000, 8'hff, 2'b00);
    xi(39'h20000, 8'h06, 2'b11);
    apb(1'b1, `LVE_OFF_CFG, 32'h08);
    xi(39'h20000, 8'hff, 2'b00);
    xi(39'ha0000, 8'h06, 2'b11);
    apb(1'b1, `LVE_OFF_CFG, 32'h02);
    xi(39'h40000, 8'h06, 2'b11);
    xi(39'h800000, 8'h07, 2'b11);
    xi(39'h1000000, 8'hff, 2'b00);
    apb(1'b1, `LVE_OFF_CFG, 32'h20);
    xi(39'h200000, 8'h06, 2'b11);
    apb(1'b1, `LVE_OFF_CFG, 32'h05);
    xi(39'h1000000, 8'h07, 2'b11);
    apb(1'b1, `LVE_OFF_CFG, 32'h04);
    xi(39'h1000000, 8'hff, 2'b00);
    xi(39'h800000, 8'h07, 2'b11);
    apb(1'b1, `LVE_OFF_CFG, 32'h0c);
    xi(39'h20000, 8'h07, 2'b11);
    xi(39'h40000, 8'h07, 2'b11);
    xi(39'h40000000, 8'hff, 2'b00);
    apb(1'b1, `LVE_OFF_DBG_CTRL, 32'h0f);
    xi(39'h240000000, 8'h01, 2'b00);
    apb(1'b0, `LVE_OFF_DBG_STAT, 32'h0);
    chk(rd, 32'h0a);
    apb(1'b1, `LVE_OFF_DBG_STAT, 32'h7f);
    apb(1'b0, `LVE_OFF_DBG_STAT, 32'h0);
    chk(rd, 32'h0);
    xi(39'h8, 8'h01, 2'b00);
    xi(39'h100000000, 8'h01, 2'b00);
    xi(39'h80000000, 8'h01, 2'b00);
    xi(39'h20000000, 8'h01, 2'b10);
    apb(1'b1, `LVE_OFF_DBG_CTRL, 32'h1f);
    xi(39'h100000, 8'h01, 2'b10);
    apb(1'b0, `LVE_OFF_DBG_STAT, 32'h0);
    chk(rd, 32'h75);
    apb(1'b1, `LVE_OFF_DBG_CTRL, 32'h01);
    xi(39'h6000000, 8'hff, 2'b00);
    chk1(resume_flag, 1'b1);
    xi(39'h20000000, 8'hff, 2'b00);
    chk1(resume_flag, 1'b0);
    xi(39'h20000000, 8'h01, 2'b10);
    xi(39'h6000000, 8'hff, 2'b00);
    xi(39'h8000000, 8'hff, 2'b00);
    chk1(resume_flag, 1'b1);
    xi(39'h1, 8'hff, 2'b00);
    chk1(resume_flag, 1'b0);
    nmi_pulse();
    xi(39'h10000000, 8'h02, 2'b11);
    chk1(nmi_blocked, 1'b1);
    nmi_pulse();
    xi(39'h1, 8'hff, 2'b00);
    xi(39'h2000000, 8'hff, 2'b00);
    chk1(nmi_blocked, 1'b0);
    xi(39'h1, 8'h02, 2'b10);
    // The last report stays readable: vector 2, blocked, pointer at the boundary.
    apb(1'b0, `LVE_OFF_EXC_INFO, 32'h0);
    chk(rd, 32'h00001002);
    chk1(err, 1'b0);
    apb(1'b0, `LVE_OFF_EXC_IP, 32'h0);
    chk(rd, ip_cur);
    end_sim();
  end
endmodule // low_vector_exception_detect_bench
`default_nettype wire
